// File: design/api_pkg.sv
// constants, register map and types of the ancillary packet inspector
package api_pkg;

	// ==================================================
	// widths
	localparam int API_AW = 12;
	localparam int API_BUF_AW = 9;
	localparam int API_NSTRM = 2;
	localparam int API_NUSER = 3;
	localparam int API_NFLAG = 4;
	localparam int API_NIRQ = 5;

	// ==================================================
	// register offsets
	localparam logic [API_AW-1:0] API_CTRL = 12'h000;
	localparam logic [API_AW-1:0] API_MATCH = 12'h004;
	localparam logic [API_AW-1:0] API_LINES = 12'h008;
	localparam logic [API_AW-1:0] API_USER0 = 12'h00C;
	localparam logic [API_AW-1:0] API_USER1 = 12'h010;
	localparam logic [API_AW-1:0] API_USER2 = 12'h014;
	localparam logic [API_AW-1:0] API_DELMK = 12'h018;
	localparam logic [API_AW-1:0] API_STAT = 12'h01C;
	localparam logic [API_AW-1:0] API_POS = 12'h020;
	localparam logic [API_AW-1:0] API_IRQ_STAT = 12'h024;
	localparam logic [API_AW-1:0] API_IRQ_MASK = 12'h028;
	localparam logic [API_AW-1:0] API_BUF_BASE = 12'h800;

	// ==================================================
	// field positions and reset values
	localparam int API_C_FREEZE = 0;
	localparam int API_C_FOT = 1;
	localparam int API_C_LS_EN = 2;
	localparam int API_C_LE_EN = 3;
	localparam int API_C_OUTSIDE = 4;
	localparam int API_C_HANC = 5;
	localparam int API_C_VANC = 6;
	localparam int API_C_TRIG = 8;
	localparam logic [31:0] API_CTRL_RST = 32'h0000_0060;
	localparam int API_M_DID = 0;
	localparam int API_M_SDID = 8;
	localparam int API_M_STRM = 16;
	localparam int API_M_ANY = 18;
	localparam int API_M_AUDIO = 19;
	localparam logic [31:0] API_MATCH_RST = 32'h0003_0000;
	localparam logic [31:0] API_ZERO_RST = 32'h0000_0000;
	localparam int API_L_START = 0;
	localparam int API_L_END = 16;
	localparam int API_S_LUMA = 0;
	localparam int API_S_FLAGS = 1;
	localparam int API_S_FROZEN = 5;
	localparam int API_S_VALID = 6;
	localparam int API_S_USER = 8;
	localparam int API_S_COUNT = 16;
	localparam int API_P_LINE = 0;
	localparam int API_P_SAMPLE = 16;
	localparam int API_F_CKS = 0;
	localparam int API_F_DBN = 1;
	localparam int API_F_PAR = 2;
	localparam int API_F_GAP = 3;
	localparam int API_I_CAP = 0;
	localparam int API_I_ERR = 1;
	localparam int API_I_FRZ = 2;
	localparam int API_I_DEL = 3;
	localparam int API_I_USER = 4;

	// ==================================================
	// word values
	localparam logic [9:0] API_ADF_LO = 10'h000;
	localparam logic [9:0] API_ADF_HI = 10'h3FF;
	localparam logic [7:0] API_EDH_DID = 8'hF4;
	localparam logic [7:0] API_DBN_ZERO = 8'h00;
	localparam logic [7:0] API_DBN_FIRST = 8'h01;
	localparam logic [7:0] API_DBN_LAST = 8'hFF;
	localparam logic [7:0] API_DC_NONE = 8'h00;
	localparam logic [7:0] API_DC_ONE = 8'h01;
	localparam logic [1:0] API_RESP_OK = 2'b00;
	localparam logic [1:0] API_RESP_ERR = 2'b10;

	typedef enum logic [2:0] {PS_IDLE, PS_ADF1, PS_ADF2, PS_DID, PS_SDID, PS_DC, PS_UDW,
		PS_CS} api_pstate_t;

	function automatic logic [31:0] api_strb(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] st);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (st[i]) begin
				r[8*i +: 8] = wd[8*i +: 8];
			end
		end
		return r;
	endfunction : api_strb

endpackage : api_pkg

// File: design/api_buf_if.sv
// packet buffer port between inspector and its memory
`timescale 1ns/1ps
interface api_buf_if;
	import api_pkg::*;
	logic we;
	logic [API_BUF_AW:0] waddr;
	logic [9:0] wdata;
	logic re;
	logic [API_BUF_AW:0] raddr;
	logic [9:0] rdata;
	modport user (output we, output waddr, output wdata, output re, output raddr, input rdata);
	modport mem (input we, input waddr, input wdata, input re, input raddr, output rdata);
endinterface : api_buf_if

// File: design/api_pkt_ram.sv
// two-bank packet word memory with registered read
`timescale 1ns/1ps
module api_pkt_ram (
	// clock
	input wire logic aclk,
	// buffer port
	api_buf_if.mem bus
);
	import api_pkg::*;

	logic [9:0] ram [2**(API_BUF_AW+1)];
	logic [9:0] q;

	always_ff @(posedge aclk) begin
		if (bus.we) begin
			ram[bus.waddr] <= bus.wdata;
		end
	end

	always_ff @(posedge aclk) begin
		if (bus.re) begin
			q <= ram[bus.raddr];
		end
	end

	assign bus.rdata = q;

endmodule : api_pkt_ram

// File: design/api_anc_inspector.sv
// ancillary packet inspector top with axi4-lite registers
//
// Decided for this implementation: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps

module api_anc_inspector #(
	parameter int LINE_W = 11,
	parameter int SAMP_W = 12
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// video word stream
	input wire logic vid_valid,
	input wire logic [9:0] vid_chroma,
	input wire logic [9:0] vid_luma,
	input wire logic [LINE_W-1:0] vid_line,
	input wire logic [SAMP_W-1:0] vid_sample,
	input wire logic vid_hblank,
	input wire logic vid_vblank,
	// axi4-lite write
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [api_pkg::API_AW-1:0] s_axi_awaddr,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	output logic [1:0] s_axi_bresp,
	// axi4-lite read
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	input wire logic [api_pkg::API_AW-1:0] s_axi_araddr,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	// interrupt
	output logic irq
);
	import api_pkg::*;

	if (LINE_W < 1 || LINE_W > 16 || SAMP_W < 1 || SAMP_W > 16) begin : g_bad
		$error("api_anc_inspector: LINE_W and SAMP_W must be 1..16");
	end

	// ==================================================
	// registers
	logic [31:0] ctrl;
	logic [31:0] match;
	logic [31:0] lines;
	logic [31:0] delmk;
	logic [31:0] irq_mask;
	logic [31:0] user_cfg [API_NUSER];
	logic [API_NIRQ-1:0] irq_stat;
	logic [API_NIRQ-1:0] ev;
	logic cap_valid;
	logic cap_luma;
	logic [API_NFLAG-1:0] cap_flags;
	logic [API_BUF_AW:0] cap_count;
	logic [LINE_W-1:0] cap_line;
	logic [SAMP_W-1:0] cap_sample;
	logic [API_NUSER-1:0] user_last;
	logic frozen;
	logic halted;

	// ==================================================
	// filters
	logic lr_en;
	logic [LINE_W-1:0] lo_line;
	logic [LINE_W-1:0] hi_line;
	logic in_range;
	logic line_ok;
	logic region_ok;
	logic insp_ok;
	logic blank;
	logic [LINE_W-1:0] prev_line;
	logic line_chg;

	assign lr_en = ctrl[API_C_LS_EN] | ctrl[API_C_LE_EN];
	assign lo_line = ctrl[API_C_LS_EN] ? lines[API_L_START +: LINE_W] : '0;
	assign hi_line = ctrl[API_C_LE_EN] ? lines[API_L_END +: LINE_W] : '1;
	assign in_range = (vid_line >= lo_line) && (vid_line <= hi_line);
	assign line_ok = !lr_en || (ctrl[API_C_OUTSIDE] ? !in_range : in_range);
	assign region_ok = (ctrl[API_C_HANC] && vid_hblank) ||
		(ctrl[API_C_VANC] && vid_vblank && !vid_hblank);
	assign insp_ok = line_ok && region_ok;
	assign blank = vid_hblank || vid_vblank;
	assign line_chg = vid_valid && (vid_line != prev_line);
	assign halted = ctrl[API_C_FREEZE] || frozen;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			prev_line <= '0;
		end else if (vid_valid) begin
			prev_line <= vid_line;
		end
	end

	// ==================================================
	// per-stream parser and checks
	logic [9:0] wrd [API_NSTRM];
	api_pstate_t pst [API_NSTRM];
	logic [7:0] pdc [API_NSTRM];
	logic [8:0] psum [API_NSTRM];
	logic [7:0] pdid [API_NSTRM];
	logic ppar [API_NSTRM];
	logic pgap [API_NSTRM];
	logic pdbn [API_NSTRM];
	logic had_pkt [API_NSTRM];
	logic gap_seen [API_NSTRM];
	logic [7:0] last_dbn [API_NSTRM];
	logic dbn_seen [API_NSTRM];
	logic [API_NFLAG-1:0] fl [API_NSTRM];
	logic [API_NSTRM-1:0] st_ok;
	logic [API_NSTRM-1:0] del_hit;
	logic [API_NUSER-1:0] uh [API_NSTRM];

	assign wrd[0] = vid_chroma;
	assign wrd[1] = vid_luma;

	for (genvar g = 0; g < API_NSTRM; g++) begin : g_strm
		logic [9:0] w;
		logic bad_par;
		logic gap_word;
		logic [7:0] dbn_next;
		logic dbn_err;
		logic dbn_chk;

		assign w = wrd[g];
		assign bad_par = (w[8] != ^w[7:0]) || (w[9] == w[8]);
		assign gap_word = (pst[g] == PS_IDLE && w != API_ADF_LO) ||
			((pst[g] == PS_ADF1 || pst[g] == PS_ADF2) && w != API_ADF_HI);
		assign dbn_next = (last_dbn[g] == API_DBN_LAST) ? API_DBN_FIRST :
			last_dbn[g] + API_DBN_FIRST;
		assign dbn_err = dbn_seen[g] && ((last_dbn[g] == API_DBN_ZERO) ?
			(w[7:0] != API_DBN_ZERO) : (w[7:0] != dbn_next));
		assign dbn_chk = match[API_M_AUDIO] && pdid[g] == match[API_M_DID +: 8];
		assign fl[g][API_F_CKS] = (w[8:0] != psum[g]) || (w[9] == w[8]);
		assign fl[g][API_F_DBN] = pdbn[g];
		assign fl[g][API_F_PAR] = ppar[g];
		assign fl[g][API_F_GAP] = pgap[g];
		assign st_ok[g] = vid_valid && pst[g] == PS_DID && insp_ok && !halted &&
			w[7:0] == match[API_M_DID +: 8] && match[API_M_STRM + g];
		assign del_hit[g] = vid_valid && pst[g] == PS_DID && blank &&
			w[7:0] == delmk[API_M_DID +: 8];

		always_comb begin
			for (int i = 0; i < API_NUSER; i++) begin
				uh[g][i] = vid_valid && pst[g] == PS_SDID &&
					pdid[g] == user_cfg[i][API_M_DID +: 8] &&
					w[7:0] == user_cfg[i][API_M_SDID +: 8] &&
					user_cfg[i][API_M_STRM + g];
			end
		end

		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				pst[g] <= PS_IDLE;
				pdc[g] <= API_DC_NONE;
			end else if (!blank) begin
				pst[g] <= PS_IDLE;
			end else if (vid_valid) begin
				case (pst[g])
					PS_IDLE: begin
						if (w == API_ADF_LO) begin
							pst[g] <= PS_ADF1;
						end
					end
					PS_ADF1: pst[g] <= (w == API_ADF_HI) ? PS_ADF2 : PS_IDLE;
					PS_ADF2: pst[g] <= (w == API_ADF_HI) ? PS_DID : PS_IDLE;
					PS_DID: pst[g] <= PS_SDID;
					PS_SDID: pst[g] <= PS_DC;
					PS_DC: begin
						pdc[g] <= w[7:0];
						pst[g] <= (w[7:0] == API_DC_NONE) ? PS_CS : PS_UDW;
					end
					PS_UDW: begin
						pdc[g] <= pdc[g] - API_DC_ONE;
						if (pdc[g] == API_DC_ONE) begin
							pst[g] <= PS_CS;
						end
					end
					default: pst[g] <= PS_IDLE;
				endcase
			end
		end

		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				psum[g] <= '0;
				ppar[g] <= 1'b0;
				pgap[g] <= 1'b0;
				pdid[g] <= '0;
			end else if (vid_valid) begin
				if (pst[g] == PS_DID) begin
					psum[g] <= w[8:0];
					ppar[g] <= bad_par;
					pgap[g] <= gap_seen[g] && w[7:0] != API_EDH_DID;
					pdid[g] <= w[7:0];
				end else if (pst[g] == PS_SDID || pst[g] == PS_DC) begin
					psum[g] <= psum[g] + w[8:0];
					ppar[g] <= ppar[g] || bad_par;
				end else if (pst[g] == PS_UDW) begin
					psum[g] <= psum[g] + w[8:0];
				end
			end
		end

		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				had_pkt[g] <= 1'b0;
				gap_seen[g] <= 1'b0;
			end else if (!blank || line_chg) begin
				had_pkt[g] <= 1'b0;
				gap_seen[g] <= 1'b0;
			end else if (vid_valid) begin
				if (pst[g] == PS_CS) begin
					had_pkt[g] <= 1'b1;
					gap_seen[g] <= 1'b0;
				end else if (had_pkt[g] && gap_word) begin
					gap_seen[g] <= 1'b1;
				end
			end
		end

		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				pdbn[g] <= 1'b0;
				last_dbn[g] <= API_DBN_ZERO;
				dbn_seen[g] <= 1'b0;
			end else if (vid_valid && pst[g] == PS_DID) begin
				pdbn[g] <= 1'b0;
			end else if (vid_valid && pst[g] == PS_SDID && dbn_chk) begin
				pdbn[g] <= dbn_err;
				last_dbn[g] <= w[7:0];
				dbn_seen[g] <= 1'b1;
			end
		end
	end

	// ==================================================
	// capture engine
	logic busy;
	logic owner;
	logic wbank;
	logic rbank;
	logic [API_BUF_AW-1:0] widx;
	logic start;
	logic st_s;
	api_pstate_t ow_st;
	logic [9:0] ow_w;
	logic ow_lost;
	logic sdid_bad;
	logic ow_cs;
	logic [API_NFLAG-1:0] fl_own;
	logic [API_NFLAG-1:0] trig;
	logic commit;
	logic [LINE_W-1:0] st_line;
	logic [SAMP_W-1:0] st_sample;

	assign start = |st_ok && !busy;
	assign st_s = !st_ok[0];
	assign ow_st = pst[owner];
	assign ow_w = wrd[owner];
	assign ow_lost = busy && (ow_st == PS_IDLE || ow_st == PS_ADF1 || ow_st == PS_ADF2);
	assign sdid_bad = busy && vid_valid && ow_st == PS_SDID && !match[API_M_ANY] &&
		ow_w[7:0] != match[API_M_SDID +: 8];
	assign ow_cs = busy && vid_valid && ow_st == PS_CS;
	assign fl_own = fl[owner];
	assign trig = ctrl[API_C_TRIG +: API_NFLAG];
	assign commit = ow_cs && (trig == '0 || (fl_own & trig) != '0);

	api_buf_if bufb ();
	assign bufb.we = start || (busy && vid_valid && !ow_lost);
	assign bufb.wdata = start ? wrd[st_s] : ow_w;
	assign bufb.waddr = {wbank, (start ? API_BUF_AW'(0) : widx)};

	api_pkt_ram u_ram (
		.aclk(aclk),
		.bus(bufb)
	);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			busy <= 1'b0;
			owner <= 1'b0;
			widx <= '0;
			st_line <= '0;
			st_sample <= '0;
		end else if (start) begin
			busy <= 1'b1;
			owner <= st_s;
			widx <= API_BUF_AW'(1);
			st_line <= vid_line;
			st_sample <= vid_sample;
		end else if (busy) begin
			if (ow_lost || sdid_bad || ow_cs) begin
				busy <= 1'b0;
			end else if (vid_valid) begin
				widx <= widx + API_BUF_AW'(1);
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cap_valid <= 1'b0;
			cap_luma <= 1'b0;
			cap_flags <= '0;
			cap_count <= '0;
			cap_line <= '0;
			cap_sample <= '0;
			wbank <= 1'b0;
			rbank <= 1'b1;
		end else if (commit) begin
			cap_valid <= 1'b1;
			cap_luma <= owner;
			cap_flags <= fl_own;
			cap_count <= {1'b0, widx} + (API_BUF_AW+1)'(1);
			cap_line <= st_line;
			cap_sample <= st_sample;
			rbank <= wbank;
			wbank <= !wbank;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			user_last <= '0;
		end else if ((uh[0] | uh[1]) != '0) begin
			user_last <= uh[0] | uh[1];
		end
	end

	// ==================================================
	// axi4-lite slave
	logic aw_full;
	logic w_full;
	logic ar_pend;
	logic do_write;
	logic wr_ok;
	logic [API_AW-1:0] aw_q;
	logic [API_AW-1:0] ar_q;
	logic [31:0] wd_q;
	logic [3:0] ws_q;
	logic [31:0] rd_mux;
	logic rd_ok;
	logic [API_NIRQ-1:0] clr;
	logic [31:0] clr_w;

	assign s_axi_awready = !aw_full && !s_axi_bvalid;
	assign s_axi_wready = !w_full && !s_axi_bvalid;
	assign s_axi_arready = !ar_pend && !s_axi_rvalid;
	assign do_write = aw_full && w_full && !s_axi_bvalid;
	assign wr_ok = aw_q == API_CTRL || aw_q == API_MATCH || aw_q == API_LINES ||
		aw_q == API_USER0 || aw_q == API_USER1 || aw_q == API_USER2 ||
		aw_q == API_DELMK || aw_q == API_IRQ_STAT || aw_q == API_IRQ_MASK;
	assign bufb.re = s_axi_arvalid && s_axi_arready;
	assign bufb.raddr = {rbank, s_axi_araddr[API_BUF_AW+1:2]};

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full <= 1'b0;
			w_full <= 1'b0;
			aw_q <= '0;
			wd_q <= '0;
			ws_q <= '0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= API_RESP_OK;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_full <= 1'b1;
				aw_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_full <= 1'b1;
				wd_q <= s_axi_wdata;
				ws_q <= s_axi_wstrb;
			end
			if (do_write) begin
				aw_full <= 1'b0;
				w_full <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_ok ? API_RESP_OK : API_RESP_ERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl <= API_CTRL_RST;
			match <= API_MATCH_RST;
			lines <= API_ZERO_RST;
			delmk <= API_ZERO_RST;
			irq_mask <= API_ZERO_RST;
			for (int i = 0; i < API_NUSER; i++) begin
				user_cfg[i] <= API_ZERO_RST;
			end
		end else if (do_write) begin
			if (aw_q == API_CTRL) begin
				ctrl <= api_strb(ctrl, wd_q, ws_q);
			end else if (aw_q == API_MATCH) begin
				match <= api_strb(match, wd_q, ws_q);
			end else if (aw_q == API_LINES) begin
				lines <= api_strb(lines, wd_q, ws_q);
			end else if (aw_q == API_USER0) begin
				user_cfg[0] <= api_strb(user_cfg[0], wd_q, ws_q);
			end else if (aw_q == API_USER1) begin
				user_cfg[1] <= api_strb(user_cfg[1], wd_q, ws_q);
			end else if (aw_q == API_USER2) begin
				user_cfg[2] <= api_strb(user_cfg[2], wd_q, ws_q);
			end else if (aw_q == API_DELMK) begin
				delmk <= api_strb(delmk, wd_q, ws_q);
			end else if (aw_q == API_IRQ_MASK) begin
				irq_mask <= api_strb(irq_mask, wd_q, ws_q);
			end
		end
	end

	// frozen: set by a trigger, cleared by writing freeze low; set wins
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			frozen <= 1'b0;
		end else if (commit && ctrl[API_C_FOT]) begin
			frozen <= 1'b1;
		end else if (do_write && aw_q == API_CTRL && ws_q[0] && !wd_q[API_C_FREEZE]) begin
			frozen <= 1'b0;
		end
	end

	// ==================================================
	// interrupts
	assign ev[API_I_CAP] = commit;
	assign ev[API_I_ERR] = commit && fl_own != '0;
	assign ev[API_I_FRZ] = commit && ctrl[API_C_FOT];
	assign ev[API_I_DEL] = |del_hit;
	assign ev[API_I_USER] = (uh[0] | uh[1]) != '0;
	assign clr_w = api_strb(API_ZERO_RST, wd_q, ws_q);
	assign clr = (do_write && aw_q == API_IRQ_STAT) ? clr_w[API_NIRQ-1:0] : '0;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_stat <= '0;
		end else begin
			irq_stat <= (irq_stat & ~clr) | ev;
		end
	end

	assign irq = (irq_stat & irq_mask[API_NIRQ-1:0]) != '0;

	// ==================================================
	// read path
	always_comb begin
		rd_mux = API_ZERO_RST;
		rd_ok = 1'b1;
		if (ar_q >= API_BUF_BASE) begin
			rd_mux = 32'(bufb.rdata);
		end else if (ar_q == API_CTRL) begin
			rd_mux = ctrl;
		end else if (ar_q == API_MATCH) begin
			rd_mux = match;
		end else if (ar_q == API_LINES) begin
			rd_mux = lines;
		end else if (ar_q == API_USER0) begin
			rd_mux = user_cfg[0];
		end else if (ar_q == API_USER1) begin
			rd_mux = user_cfg[1];
		end else if (ar_q == API_USER2) begin
			rd_mux = user_cfg[2];
		end else if (ar_q == API_DELMK) begin
			rd_mux = delmk;
		end else if (ar_q == API_STAT) begin
			rd_mux[API_S_LUMA] = cap_luma;
			rd_mux[API_S_FLAGS +: API_NFLAG] = cap_flags;
			rd_mux[API_S_FROZEN] = frozen;
			rd_mux[API_S_VALID] = cap_valid;
			rd_mux[API_S_USER +: API_NUSER] = user_last;
			rd_mux[API_S_COUNT +: API_BUF_AW+1] = cap_count;
		end else if (ar_q == API_POS) begin
			rd_mux[API_P_LINE +: LINE_W] = cap_line;
			rd_mux[API_P_SAMPLE +: SAMP_W] = cap_sample;
		end else if (ar_q == API_IRQ_STAT) begin
			rd_mux = 32'(irq_stat);
		end else if (ar_q == API_IRQ_MASK) begin
			rd_mux = irq_mask;
		end else begin
			rd_ok = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ar_pend <= 1'b0;
			ar_q <= '0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= API_ZERO_RST;
			s_axi_rresp <= API_RESP_OK;
		end else if (s_axi_arvalid && s_axi_arready) begin
			ar_pend <= 1'b1;
			ar_q <= s_axi_araddr;
		end else if (ar_pend) begin
			ar_pend <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_mux;
			s_axi_rresp <= rd_ok ? API_RESP_OK : API_RESP_ERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

endmodule : api_anc_inspector

// File: tb/api_monitor.sv
// bus and interrupt checks on the inspector top ports
`timescale 1ns/1ps
module api_monitor (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// register bus
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	// interrupt
	input wire logic irq
);
	// ==================================================
	// assertions
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped early");
	AST_R_LAT: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
		else $error("read answer late");
	AST_B_LAT: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|-> ##[1:2] s_axi_bvalid) else $error("write answer late");
	AST_AR_BLK: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while answer pending");
	AST_AW_BLK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while answer pending");
	AST_B_ONE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write response repeated");
	AST_IRQ_FALL: assert property ($fell(irq) |-> $rose(s_axi_bvalid))
		else $error("interrupt fell without a write");
endmodule : api_monitor

bind api_anc_inspector api_monitor u_mon (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .irq);

// File: tb/api_vid_src.sv
// video word source standing in for the deserialiser
`timescale 1ns/1ps
module api_vid_src (
	// clock
	input wire logic aclk,
	// video stream
	output logic vid_valid,
	output logic [9:0] vid_chroma,
	output logic [9:0] vid_luma,
	output logic [10:0] vid_line,
	output logic [11:0] vid_sample,
	output logic vid_hblank,
	output logic vid_vblank
);
	// ==================================================
	// packet sender, err: b0 checksum, b1 parity, b2 gap word first
	logic [8:0] sum;
	initial begin
		{vid_valid, vid_chroma, vid_line, vid_sample, vid_hblank, vid_vblank} = '0;
		vid_luma = 10'h040;
	end
	function automatic logic [9:0] pw(input logic [7:0] b);
		return {~^b, ^b, b};
	endfunction : pw
	task put(input logic [9:0] w);
		@(posedge aclk);
		vid_valid <= 1'b1;
		vid_chroma <= w;
		vid_sample <= vid_sample + 12'h001;
	endtask : put
	task pkt(input logic [7:0] did, input logic [10:0] ln, input logic [2:0] err);
		logic [9:0] w[7];
		w = '{10'h000, 10'h3FF, 10'h3FF, pw(did), pw(8'h01), pw(8'h01), pw(8'h5A)};
		if (err[1]) w[3][9] = w[3][8];
		sum = (w[3][8:0] + w[4][8:0] + w[5][8:0] + w[6][8:0]) ^ {8'h00, err[0]};
		@(posedge aclk);
		vid_line <= ln;
		vid_hblank <= 1'b1;
		if (err[2]) put(10'h200);
		foreach (w[i]) put(w[i]);
		put({~sum[8], sum});
		@(posedge aclk);
		vid_valid <= 1'b0;
		@(posedge aclk);
	endtask : pkt
endmodule : api_vid_src

// File: tb/test_api_anc_inspector.sv
// register-level tests of the ancillary packet inspector
`timescale 1ns/1ps
module test_api_anc_inspector;
	import api_pkg::*;
	logic aclk, aresetn, vid_valid, vid_hblank, vid_vblank, irq;
	logic [9:0] vid_chroma, vid_luma;
	logic [10:0] vid_line;
	logic [11:0] vid_sample;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	int bad_count, cmp_count;
	api_anc_inspector u_dut (.aclk, .aresetn, .vid_valid, .vid_chroma, .vid_luma, .vid_line,
		.vid_sample, .vid_hblank, .vid_vblank, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
		.s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready,
		.s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
		.s_axi_rready, .s_axi_rdata, .s_axi_rresp, .irq);
	api_vid_src src (.aclk, .vid_valid, .vid_chroma, .vid_luma, .vid_line, .vid_sample,
		.vid_hblank, .vid_vblank);
	// ==================================================
	// bus tasks
	task chk(input string n, input logic [33:0] g, input logic [33:0] e);
		cmp_count++;
		if (g !== e) begin
			bad_count++;
			$display("mismatch %s exp %h got %h", n, e, g);
		end
	endtask : chk
	task wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er = API_RESP_OK);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		chk("bresp", s_axi_bresp, er);
		@(posedge aclk);
	endtask : wr
	task cr(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e,
		input logic [1:0] er = API_RESP_OK);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'b11;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
		chk("register", {s_axi_rresp, s_axi_rdata & m}, {er, e});
		@(posedge aclk);
	endtask : cr
	task cap(input logic [7:0] did, input logic [10:0] ln, input logic [2:0] err, input logic e);
		wr(API_IRQ_STAT, 32'h0000_001F);
		src.pkt(did, ln, err);
		cr(API_IRQ_STAT, 32'h0000_0001, {31'h0, e});
	endtask : cap
	task finish_test;
		$display("checks %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : finish_test
	// ==================================================
	// clock, watchdog, tests
	initial begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end
	initial begin
		#500us;
		bad_count++;
		finish_test;
	end
	initial begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hF;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		cr(API_CTRL, 32'hFFFF_FFFF, API_CTRL_RST);
		cr(API_MATCH, 32'hFFFF_FFFF, API_MATCH_RST);
		cr(12'h0FC, 32'hFFFF_FFFF, 32'h0, API_RESP_ERR);
		wr(API_BUF_BASE, 32'h0000_0000, API_RESP_ERR);
		wr(API_MATCH, 32'h0003_0145);
		wr(API_IRQ_MASK, 32'h0000_0001);
		wr(API_USER1, 32'h0001_0145);
		src.pkt(8'h45, 11'd3, 3'b000);
		chk("irq", irq, 34'h1);
		cr(API_STAT, 32'h0000_077F, 32'h0000_0240);
		cr(API_POS, 32'h0FFF_07FF, 32'h0004_0003);
		cr(API_BUF_BASE, 32'h0000_03FF, 32'h0000_0145);
		wr(API_IRQ_STAT, 32'h0000_001F);
		chk("irq", irq, 34'h0);
		wr(API_DELMK, 32'h0000_0046);
		cap(8'h46, 11'd4, 3'b000, 1'b0);
		cr(API_IRQ_STAT, 32'h0000_0008, 32'h0000_0008);
		cap(8'h45, 11'd5, 3'b001, 1'b1);
		cr(API_STAT, 32'h0000_001E, 32'h0000_0002);
		cap(8'h45, 11'd6, 3'b010, 1'b1);
		cr(API_STAT, 32'h0000_001E, 32'h0000_0008);
		src.pkt(8'h45, 11'd7, 3'b000);
		src.pkt(8'h45, 11'd7, 3'b100);
		cr(API_STAT, 32'h0000_001E, 32'h0000_0010);
		wr(API_LINES, 32'h000C_000A);
		wr(API_CTRL, 32'h0000_006C);
		cap(8'h45, 11'd10, 3'b000, 1'b1);
		cap(8'h45, 11'd13, 3'b000, 1'b0);
		wr(API_CTRL, 32'h0000_0078);
		cap(8'h45, 11'd11, 3'b000, 1'b0);
		cap(8'h45, 11'd13, 3'b000, 1'b1);
		wr(API_CTRL, 32'h0000_0070);
		cap(8'h45, 11'd11, 3'b000, 1'b1);
		wr(API_CTRL, 32'h0000_0050);
		cap(8'h45, 11'd20, 3'b000, 1'b0);
		wr(API_CTRL, 32'h0000_0162);
		cap(8'h45, 11'd21, 3'b000, 1'b0);
		cap(8'h45, 11'd22, 3'b001, 1'b1);
		cr(API_STAT, 32'h0000_0020, 32'h0000_0020);
		cap(8'h45, 11'd23, 3'b001, 1'b0);
		wr(API_CTRL, 32'h0000_0060);
		cap(8'h45, 11'd24, 3'b000, 1'b1);
		wr(API_MATCH, 32'h000F_0145);
		cap(8'h45, 11'd30, 3'b000, 1'b1);
		cap(8'h45, 11'd31, 3'b000, 1'b1);
		cr(API_STAT, 32'h0000_001E, 32'h0000_0004);
		wr(API_MATCH, 32'h0003_01F4);
		src.pkt(8'h45, 11'd40, 3'b000);
		src.pkt(8'hF4, 11'd40, 3'b100);
		cr(API_STAT, 32'h0000_001E, 32'h0000_0000);
		wr(API_MATCH, 32'h0003_0146);
		src.pkt(8'h45, 11'd41, 3'b000);
		src.pkt(8'h46, 11'd41, 3'b100);
		cr(API_STAT, 32'h0000_001E, 32'h0000_0010);
		finish_test;
	end
endmodule : test_api_anc_inspector
